// ==== hw/adcc_conv_seq.sv ====
// Conversion start sequencer: optional delay, acquisition, conversion.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_regs.svh"
module adcc_conv_seq (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic conv_done,
  adcc_ctl_if.seq ctl
);
  adcc_pkg::adcc_seq_state_t state_ff;
  adcc_pkg::adcc_seq_state_t nxt_state;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic nxt_conv_start;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_conv_start = 1'b0;
    unique case (state_ff)
      adcc_pkg::ADCC_SEQ_IDLE: begin
        if (ctl.start && ctl.enable) begin
          if (ctl.acq_sel == 3'h0) begin
            // Leaves one instruction cycle for the core to go to sleep.
            nxt_state = adcc_pkg::ADCC_SEQ_DELAY;
            nxt_cnt = 8'(`ADCC_INSN_CYC);
          end else begin
            nxt_state = adcc_pkg::ADCC_SEQ_ACQ;
            nxt_cnt = 8'(ctl.acq_sel * `ADCC_ACQ_UNIT_CYC);
          end
        end
      end
      adcc_pkg::ADCC_SEQ_DELAY, adcc_pkg::ADCC_SEQ_ACQ: begin
        nxt_cnt = cnt_ff - 8'h01;
        if (cnt_ff == 8'h01) begin
          nxt_state = adcc_pkg::ADCC_SEQ_CONV;
          nxt_conv_start = 1'b1;
        end
      end
      adcc_pkg::ADCC_SEQ_CONV: begin
        if (conv_done) begin
          nxt_state = adcc_pkg::ADCC_SEQ_IDLE;
        end
      end
      default: nxt_state = adcc_pkg::ADCC_SEQ_IDLE;
    endcase
    // Dropping the enable abandons any conversion under way.
    if (!ctl.enable) begin
      nxt_state = adcc_pkg::ADCC_SEQ_IDLE;
      nxt_conv_start = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= adcc_pkg::ADCC_SEQ_IDLE;
      cnt_ff <= 8'h00;
      ctl.conv_start <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      ctl.conv_start <= nxt_conv_start;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctl.busy <= 1'b0;
      ctl.acquiring <= 1'b0;
      ctl.converting <= 1'b0;
    end else begin
      ctl.busy <= nxt_state != adcc_pkg::ADCC_SEQ_IDLE;
      ctl.acquiring <= nxt_state == adcc_pkg::ADCC_SEQ_ACQ;
      ctl.converting <= nxt_state == adcc_pkg::ADCC_SEQ_CONV;
    end
  end
endmodule : adcc_conv_seq
`default_nettype wire

// ==== hw/adcc_ctl_if.sv ====
// Control link between the register block and the conversion sequencer.
`timescale 1ns/1ps
`default_nettype none
interface adcc_ctl_if;
  logic enable;
  logic start;
  logic [2:0] acq_sel;
  logic busy;
  logic acquiring;
  logic converting;
  logic conv_start;

  modport regs (output enable, output start, output acq_sel,
                input busy, input acquiring, input converting,
                input conv_start);
  modport seq (input enable, input start, input acq_sel,
               output busy, output acquiring, output converting,
               output conv_start);
endinterface : adcc_ctl_if
`default_nettype wire

// ==== hw/adcc_pkg.sv ====
// Types shared by the converter trigger and reference control block.
package adcc_pkg;

  typedef enum logic [1:0] {
    ADCC_TRIG_ENHANCED_CAPTURE_COMPARE_ONE = 2'h0,
    ADCC_TRIG_CHARGE_TIME_MEASUREMENT_UNIT = 2'h1,
    ADCC_TRIG_TIMER1 = 2'h2,
    ADCC_TRIG_CAPTURE_COMPARE_UNIT_TWO = 2'h3
  } adcc_trig_src_t;

  typedef enum logic [3:0] {
    ADCC_SEQ_IDLE = 4'b0001,
    ADCC_SEQ_DELAY = 4'b0010,
    ADCC_SEQ_ACQ = 4'b0100,
    ADCC_SEQ_CONV = 4'b1000
  } adcc_seq_state_t;

endpackage : adcc_pkg

// ==== hw/adcc_regs.svh ====
// Register offsets, field positions, reset values and timing counts.
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

`define ADCC_ADDR_W 8
`define ADCC_TRIGREF_OFS 8'h00
`define ADCC_CTRL_OFS 8'h04
`define ADCC_TIMING_OFS 8'h08
`define ADCC_SRCCFG_OFS 8'h0c
`define ADCC_STATUS_OFS 8'h10

`define ADCC_TRIGREF_RST 8'h00
`define ADCC_TIMING_RST 6'h00
`define ADCC_SRCCFG_RST 6'h00

`define ADCC_TSEL_LSB 6
`define ADCC_POSITIVE_REFERENCE_SELECT_LSB 4
`define ADCC_NEGATIVE_REFERENCE_SELECT_BIT 3
`define ADCC_NEGATIVE_CHANNEL_SELECT_LSB 0
`define ADCC_CTRL_EN_BIT 0
`define ADCC_CTRL_GO_BIT 1
`define ADCC_ACQUISITION_TIME_SELECT_LSB 3
`define ADCC_CONVERSION_CLOCK_SELECT_LSB 0
`define ADCC_COMPARE_UNIT_TWO_MODE_LSB 0
`define ADCC_MTRIG_BIT 8
`define ADCC_T3SEL_BIT 9

`define ADCC_CAPTURE_COMPARE_UNIT_TWO_SPECIAL 4'hb
`define ADCC_RESP_OKAY 2'h0
`define ADCC_RESP_SLVERR 2'h2

`define ADCC_CLK_MHZ 100
`define ADCC_INSN_NS 40
`define ADCC_ACQ_UNIT_NS 200
`define ADCC_INSN_CYC ((`ADCC_INSN_NS * `ADCC_CLK_MHZ + 999) / 1000)
`define ADCC_ACQ_UNIT_CYC ((`ADCC_ACQ_UNIT_NS * `ADCC_CLK_MHZ + 999) / 1000)

`endif

// ==== hw/adcc_top.sv ====
// Converter trigger and reference control with an AXI4-Lite register slave.
// What this block does
// - Start conversions from compare unit two, enhanced unit one, CHARGE_TIME_MEASUREMENT_UNIT or Timer1.
// - Compare unit two triggers only when its mode field is 1011.
// - Measurement unit triggers only while its trigger enable bit is set.
// - Enabled trigger sets the busy bit and begins acquisition, or the sleep delay when acquisition select is 000.
// - With the converter disabled every trigger is ignored.
// - Capture/compare triggers clear Timer1 or Timer3, even when disabled.
// - Acquisition select 000 delays conversion by one instruction cycle.
// - Positive reference: 11 4.1V, 10 2.0V, 01 external pin, 00 supply.
// - Negative reference bit: 1 external pin, 0 analog ground.
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_regs.svh"
module adcc_top (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic capture_compare_unit_two_event,
  input wire logic enhanced_capture_compare_one_event,
  input wire logic charge_time_measurement_unit_event,
  input wire logic timer1_event,
  input wire logic conv_done,
  output logic conv_start,
  output logic conversion_busy,
  output logic acquiring,
  output logic timer1_clear,
  output logic timer3_clear,
  output logic [3:0] pos_ref_onehot,
  output logic neg_ref_external,
  output logic [7:0] neg_input_route,
  output logic [2:0] conversion_clock_select
);
  adcc_ctl_if ctl ();

  logic [7:0] trigref_ff;
  logic [5:0] timing_ff;
  logic [5:0] srccfg_ff;
  logic enable_ff;
  logic sw_go_ff;
  logic trig_start;

  logic aw_hold_ff;
  logic [7:0] aw_addr_ff;
  logic w_hold_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic nxt_aw_hold;
  logic nxt_w_hold;
  logic nxt_rvalid;
  logic wr_fire;
  logic rd_fire;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;

  logic [3:0] pos_ref_ff;
  logic neg_ref_ff;
  logic [7:0] neg_route_ff;
  logic [2:0] clk_sel_ff;

  // Write address and data are taken independently and held until answered.
  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold = w_hold_ff;
    if (s_axil_awvalid && awready_ff) begin
      nxt_aw_hold = 1'b1;
    end else if (bvalid_ff && s_axil_bready) begin
      nxt_aw_hold = 1'b0;
    end
    if (s_axil_wvalid && wready_ff) begin
      nxt_w_hold = 1'b1;
    end else if (bvalid_ff && s_axil_bready) begin
      nxt_w_hold = 1'b0;
    end
  end

  assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      awready_ff <= !nxt_aw_hold;
      wready_ff <= !nxt_w_hold;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else begin
      if (s_axil_awvalid && awready_ff) begin
        aw_addr_ff <= s_axil_awaddr;
      end
      if (s_axil_wvalid && wready_ff) begin
        w_data_ff <= s_axil_wdata;
        w_strb_ff <= s_axil_wstrb;
      end
    end
  end

  always_comb begin
    unique case (aw_addr_ff)
      `ADCC_TRIGREF_OFS, `ADCC_CTRL_OFS, `ADCC_TIMING_OFS,
      `ADCC_SRCCFG_OFS, `ADCC_STATUS_OFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `ADCC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
    end else if (s_axil_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Register writes; the status word is read-only and ignores writes.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      trigref_ff <= `ADCC_TRIGREF_RST;
      timing_ff <= `ADCC_TIMING_RST;
      srccfg_ff <= `ADCC_SRCCFG_RST;
      enable_ff <= 1'b0;
    end else if (wr_fire) begin
      if (aw_addr_ff == `ADCC_TRIGREF_OFS && w_strb_ff[0]) begin
        trigref_ff <= w_data_ff[7:0];
      end
      if (aw_addr_ff == `ADCC_CTRL_OFS && w_strb_ff[0]) begin
        enable_ff <= w_data_ff[`ADCC_CTRL_EN_BIT];
      end
      if (aw_addr_ff == `ADCC_TIMING_OFS && w_strb_ff[0]) begin
        timing_ff <= w_data_ff[5:0];
      end
      if (aw_addr_ff == `ADCC_SRCCFG_OFS) begin
        if (w_strb_ff[0]) begin
          srccfg_ff[3:0] <= w_data_ff[`ADCC_COMPARE_UNIT_TWO_MODE_LSB +: 4];
        end
        if (w_strb_ff[1]) begin
          srccfg_ff[4] <= w_data_ff[`ADCC_MTRIG_BIT];
          srccfg_ff[5] <= w_data_ff[`ADCC_T3SEL_BIT];
        end
      end
    end
  end

  // A software start is honoured only with the enable bit set in the
  // same write, so a disabled converter never latches a stale request.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sw_go_ff <= 1'b0;
    end else begin
      sw_go_ff <= wr_fire && aw_addr_ff == `ADCC_CTRL_OFS && w_strb_ff[0] &&
                  w_data_ff[`ADCC_CTRL_GO_BIT] &&
                  w_data_ff[`ADCC_CTRL_EN_BIT];
    end
  end

  // Reads answer one cycle after the address is taken.
  assign rd_fire = s_axil_arvalid && arready_ff;
  assign nxt_rvalid = rd_fire || (rvalid_ff && !s_axil_rready);

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (s_axil_araddr)
      `ADCC_TRIGREF_OFS: rd_word[7:0] = trigref_ff;
      `ADCC_CTRL_OFS: begin
        rd_word[`ADCC_CTRL_EN_BIT] = enable_ff;
        rd_word[`ADCC_CTRL_GO_BIT] = ctl.busy;
      end
      `ADCC_TIMING_OFS: rd_word[5:0] = timing_ff;
      `ADCC_SRCCFG_OFS: begin
        rd_word[`ADCC_COMPARE_UNIT_TWO_MODE_LSB +: 4] = srccfg_ff[3:0];
        rd_word[`ADCC_MTRIG_BIT] = srccfg_ff[4];
        rd_word[`ADCC_T3SEL_BIT] = srccfg_ff[5];
      end
      `ADCC_STATUS_OFS: begin
        rd_word[0] = ctl.busy;
        rd_word[1] = ctl.acquiring;
        rd_word[2] = ctl.converting;
        rd_word[3] = enable_ff;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `ADCC_RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      arready_ff <= !nxt_rvalid;
      if (rd_fire) begin
        rdata_ff <= rd_word;
        rresp_ff <= rd_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
      end
    end
  end

  adcc_trig_sel u_trig (
    .sys_clk(sys_clk),
    .reset(reset),
    .capture_compare_unit_two_event(capture_compare_unit_two_event),
    .enhanced_capture_compare_one_event(enhanced_capture_compare_one_event),
    .charge_time_measurement_unit_event(charge_time_measurement_unit_event),
    .timer1_event(timer1_event),
    .compare_unit_two_mode(srccfg_ff[3:0]),
    .measurement_unit_trigger_enable(srccfg_ff[4]),
    .trigger_source_select(trigref_ff[`ADCC_TSEL_LSB +: 2]),
    .converter_enable(enable_ff),
    .timer3_select(srccfg_ff[5]),
    .start_ff(trig_start),
    .timer1_clear_ff(timer1_clear),
    .timer3_clear_ff(timer3_clear)
  );

  assign ctl.enable = enable_ff;
  assign ctl.start = trig_start || sw_go_ff;
  assign ctl.acq_sel = timing_ff[`ADCC_ACQUISITION_TIME_SELECT_LSB +: 3];

  adcc_conv_seq u_seq (
    .sys_clk(sys_clk),
    .reset(reset),
    .conv_done(conv_done),
    .ctl(ctl)
  );

  // Analog selects are registered so the switches never see decode glitches.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pos_ref_ff <= 4'h1;
      neg_ref_ff <= 1'b0;
      neg_route_ff <= 8'h01;
      clk_sel_ff <= 3'h0;
    end else begin
      pos_ref_ff <= 4'h1 << trigref_ff[`ADCC_POSITIVE_REFERENCE_SELECT_LSB +: 2];
      neg_ref_ff <= trigref_ff[`ADCC_NEGATIVE_REFERENCE_SELECT_BIT];
      neg_route_ff <= 8'h01 << trigref_ff[`ADCC_NEGATIVE_CHANNEL_SELECT_LSB +: 3];
      clk_sel_ff <= timing_ff[`ADCC_CONVERSION_CLOCK_SELECT_LSB +: 3];
    end
  end

  assign s_axil_awready = awready_ff;
  assign s_axil_wready = wready_ff;
  assign s_axil_bvalid = bvalid_ff;
  assign s_axil_bresp = bresp_ff;
  assign s_axil_arready = arready_ff;
  assign s_axil_rvalid = rvalid_ff;
  assign s_axil_rdata = rdata_ff;
  assign s_axil_rresp = rresp_ff;
  assign conv_start = ctl.conv_start;
  assign conversion_busy = ctl.busy;
  assign acquiring = ctl.acquiring;
  assign pos_ref_onehot = pos_ref_ff;
  assign neg_ref_external = neg_ref_ff;
  assign neg_input_route = neg_route_ff;
  assign conversion_clock_select = clk_sel_ff;
endmodule : adcc_top
`default_nettype wire

// ==== hw/adcc_trig_sel.sv ====
// Special event trigger qualification, selection and timer clearing.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_regs.svh"
module adcc_trig_sel (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic capture_compare_unit_two_event,
  input wire logic enhanced_capture_compare_one_event,
  input wire logic charge_time_measurement_unit_event,
  input wire logic timer1_event,
  input wire logic [3:0] compare_unit_two_mode,
  input wire logic measurement_unit_trigger_enable,
  input wire logic [1:0] trigger_source_select,
  input wire logic converter_enable,
  input wire logic timer3_select,
  output logic start_ff,
  output logic timer1_clear_ff,
  output logic timer3_clear_ff
);
  logic capture_compare_unit_two_ok;
  logic charge_time_measurement_unit_ok;
  logic picked;
  logic ccp_fire;

  assign capture_compare_unit_two_ok = capture_compare_unit_two_event &&
                   (compare_unit_two_mode == `ADCC_CAPTURE_COMPARE_UNIT_TWO_SPECIAL);
  assign charge_time_measurement_unit_ok = charge_time_measurement_unit_event && measurement_unit_trigger_enable;

  always_comb begin
    unique case (adcc_pkg::adcc_trig_src_t'(trigger_source_select))
      adcc_pkg::ADCC_TRIG_CAPTURE_COMPARE_UNIT_TWO: picked = capture_compare_unit_two_ok;
      adcc_pkg::ADCC_TRIG_TIMER1: picked = timer1_event;
      adcc_pkg::ADCC_TRIG_CHARGE_TIME_MEASUREMENT_UNIT: picked = charge_time_measurement_unit_ok;
      adcc_pkg::ADCC_TRIG_ENHANCED_CAPTURE_COMPARE_ONE: picked = enhanced_capture_compare_one_event;
    endcase
  end

  // The timer clear does not depend on the converter being enabled.
  assign ccp_fire = capture_compare_unit_two_ok || enhanced_capture_compare_one_event;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      start_ff <= 1'b0;
    end else begin
      start_ff <= picked && converter_enable;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      timer1_clear_ff <= 1'b0;
      timer3_clear_ff <= 1'b0;
    end else begin
      timer1_clear_ff <= ccp_fire && !timer3_select;
      timer3_clear_ff <= ccp_fire && timer3_select;
    end
  end
endmodule : adcc_trig_sel
`default_nettype wire

// ==== testbench/adc_trigger_and_reference_control_bench.sv ====
// Self-checking bench for the converter trigger and reference control.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_regs.svh"
module adc_trigger_and_reference_control_bench;
  localparam logic [1:0] RSP_OK = `ADCC_RESP_OKAY;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
  logic [31:0] s_axil_wdata = 32'h0000_0000, s_axil_rdata;
  logic [3:0] s_axil_wstrb = 4'hf;
  logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
  logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid;
  logic s_axil_arready, s_axil_rvalid;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic [3:0] fire = 4'h0;
  logic slow = 1'b0;
  logic capture_compare_unit_two_event, enhanced_capture_compare_one_event, charge_time_measurement_unit_event, timer1_event, conv_done;
  logic conv_start, conversion_busy, acquiring, timer1_clear, timer3_clear;
  logic [3:0] pos_ref_onehot;
  logic neg_ref_external;
  logic [7:0] neg_input_route;
  logic [2:0] conversion_clock_select;
  int err_total = 0;
  int checks_done = 0;

  adcc_top i_dut (
    .sys_clk, .reset, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
    .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready,
    .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr,
    .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp,
    .s_axil_rvalid, .s_axil_rready, .capture_compare_unit_two_event, .enhanced_capture_compare_one_event, .charge_time_measurement_unit_event,
    .timer1_event, .conv_done, .conv_start, .conversion_busy, .acquiring,
    .timer1_clear, .timer3_clear, .pos_ref_onehot, .neg_ref_external,
    .neg_input_route, .conversion_clock_select
  );
  adcc_src_model i_src (
    .sys_clk, .reset, .fire, .slow, .conv_start, .enhanced_capture_compare_one_event, .charge_time_measurement_unit_event,
    .timer1_event, .capture_compare_unit_two_event, .conv_done
  );

  always #5 sys_clk = ~sys_clk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic lost();
    err_total++;
    $display("unexpected at %0t: wait ran out", $time);
    close_out();
  endtask : lost

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check

  // Values are sampled at the edge itself, before the design's updates land.
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] xr);
    int n;
    @(posedge sys_clk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s_axil_awvalid && s_axil_awready) begin
        s_axil_awvalid <= 1'b0;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        s_axil_wvalid <= 1'b0;
      end
      if (s_axil_bvalid) begin
        s_axil_bready <= 1'b0;
        check(s_axil_bresp, xr);
        break;
      end
    end
    if (n == 50) lost();
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] xd,
                     input logic [1:0] xr);
    int n;
    @(posedge sys_clk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s_axil_arvalid && s_axil_arready) begin
        s_axil_arvalid <= 1'b0;
      end
      if (s_axil_rvalid) begin
        s_axil_rready <= 1'b0;
        check(s_axil_rdata, xd);
        check(s_axil_rresp, xr);
        break;
      end
    end
    if (n == 50) lost();
  endtask : axr

  // Fires one source, then watches clears, busy and the start pulse.
  task automatic trig(input int src, input logic xb, input logic [1:0] xc,
                      output logic sa);
    logic sb, ss;
    logic [1:0] sc;
    int n;
    sb = 1'b0;
    ss = 1'b0;
    sc = 2'b00;
    sa = 1'b0;
    @(posedge sys_clk);
    fire <= 4'h1 << src;
    @(posedge sys_clk);
    fire <= 4'h0;
    for (n = 0; n < 210; n++) begin
      @(posedge sys_clk);
      sc |= {timer3_clear, timer1_clear};
      sb |= conversion_busy;
      sa |= acquiring;
      ss |= conv_start;
      if (n > 6 && !conversion_busy) break;
    end
    if (n == 210) lost();
    check(sc, xc);
    check(sb, xb);
    check(ss, xb);
  endtask : trig

  initial begin : watchdog
    repeat (30000) @(posedge sys_clk);
    lost();
  end

  initial begin : main
    int i;
    logic a;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    axr(`ADCC_TRIGREF_OFS, 32'h0000_0000, RSP_OK);
    check(pos_ref_onehot, 32'h0000_0001);
    check(neg_input_route, 32'h0000_0001);
    axr(8'h14, 32'h0000_0000, `ADCC_RESP_SLVERR);
    axw(8'h14, 32'h0000_00ff, `ADCC_RESP_SLVERR);
    for (i = 0; i < 8; i++) begin
      axw(`ADCC_TRIGREF_OFS, {26'h000_0000, i[1:0], i[0], i[2:0]}, RSP_OK);
      axr(`ADCC_TRIGREF_OFS, {26'h000_0000, i[1:0], i[0], i[2:0]}, RSP_OK);
      check(pos_ref_onehot, 32'h0000_0001 << i[1:0]);
      check(neg_ref_external, i[0]);
      check(neg_input_route, 32'h0000_0001 << i);
    end
    axw(`ADCC_TIMING_OFS, 32'h0000_0008, RSP_OK);
    axw(`ADCC_SRCCFG_OFS, 32'h0000_010b, RSP_OK);
    trig(0, 1'b0, 2'b01, a);
    axw(`ADCC_CTRL_OFS, 32'h0000_0001, RSP_OK);
    for (i = 0; i < 4; i++) begin
      axw(`ADCC_TRIGREF_OFS, {24'h00_0000, i[1:0], 6'h00}, RSP_OK);
      slow <= i[0];
      trig((i + 1) % 4, 1'b0, {1'b0, i > 1}, a);
      trig(i, 1'b1, {1'b0, i == 0 || i == 3}, a);
      check(a, 1'b1);
    end
    axw(`ADCC_SRCCFG_OFS, 32'h0000_010a, RSP_OK);
    trig(3, 1'b0, 2'b00, a);
    axw(`ADCC_SRCCFG_OFS, 32'h0000_020b, RSP_OK);
    trig(3, 1'b1, 2'b10, a);
    axw(`ADCC_TRIGREF_OFS, 32'h0000_0040, RSP_OK);
    trig(1, 1'b0, 2'b00, a);
    axw(`ADCC_TRIGREF_OFS, 32'h0000_0080, RSP_OK);
    axw(`ADCC_TIMING_OFS, 32'h0000_0005, RSP_OK);
    // The clock select output follows the timing word one cycle later.
    @(posedge sys_clk);
    check(conversion_clock_select, 32'h0000_0005);
    trig(2, 1'b1, 2'b00, a);
    check(a, 1'b0);
    axr(`ADCC_STATUS_OFS, 32'h0000_0008, RSP_OK);
    axw(`ADCC_STATUS_OFS, 32'h0000_0007, RSP_OK);
    axr(`ADCC_STATUS_OFS, 32'h0000_0008, RSP_OK);
    axw(`ADCC_CTRL_OFS, 32'h0000_0003, RSP_OK);
    axr(`ADCC_CTRL_OFS, 32'h0000_0003, RSP_OK);
    axr(`ADCC_STATUS_OFS, 32'h0000_000d, RSP_OK);
    // Dropping the enable in mid-conversion must abandon the conversion.
    axw(`ADCC_CTRL_OFS, 32'h0000_0000, RSP_OK);
    axr(`ADCC_STATUS_OFS, 32'h0000_0000, RSP_OK);
    trig(2, 1'b0, 2'b00, a);
    close_out();
  end
endmodule : adc_trigger_and_reference_control_bench

bind adcc_top adcc_top_chk i_chk (
  .sys_clk, .reset, .capture_compare_unit_two_event, .enhanced_capture_compare_one_event, .conv_done, .conv_start,
  .conversion_busy, .acquiring, .timer1_clear, .timer3_clear,
  .pos_ref_onehot, .neg_input_route
);
`default_nettype wire

// ==== testbench/adcc_src_model.sv ====
// Trigger sources and analog core stand-in facing the control block.
`timescale 1ns/1ps
`default_nettype none
module adcc_src_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] fire,
  input wire logic slow,
  input wire logic conv_start,
  output logic enhanced_capture_compare_one_event,
  output logic charge_time_measurement_unit_event,
  output logic timer1_event,
  output logic capture_compare_unit_two_event,
  output logic conv_done
);
  logic [4:0] wait_ff;
  // Bit order of fire follows the trigger select encoding.
  always_ff @(posedge sys_clk) begin
    {capture_compare_unit_two_event, timer1_event, charge_time_measurement_unit_event, enhanced_capture_compare_one_event} <= reset ? 4'h0 : fire;
  end
  // A slow core keeps busy up long enough to expose early release.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wait_ff <= 5'h00;
    end else if (conv_start) begin
      wait_ff <= slow ? 5'h10 : 5'h02;
    end else if (wait_ff != 5'h00) begin
      wait_ff <= wait_ff - 5'h01;
    end
  end
  assign conv_done = (wait_ff == 5'h01);
endmodule : adcc_src_model
`default_nettype wire

// ==== testbench/adcc_top_chk_sva.sv ====
// Concurrent checks on the ports of the converter trigger control block.
`timescale 1ns/1ps
`default_nettype none
module adcc_top_chk (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic capture_compare_unit_two_event,
  input wire logic enhanced_capture_compare_one_event,
  input wire logic conv_done,
  input wire logic conv_start,
  input wire logic conversion_busy,
  input wire logic acquiring,
  input wire logic timer1_clear,
  input wire logic timer3_clear,
  input wire logic [3:0] pos_ref_onehot,
  input wire logic [7:0] neg_input_route
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_clear_next;
    ##1 (timer1_clear || timer3_clear);
  endsequence
  // The sleep delay must not show as acquisition and must end in a start.
  sequence s_delayed_start;
    (!acquiring) throughout (##[3:8] conv_start);
  endsequence

  chk_enhanced_capture_compare_one_clear: assert property (enhanced_capture_compare_one_event |-> s_clear_next)
    else $error("enhanced unit event gave no timer clear");
  chk_clear_cause: assert property ((timer1_clear || timer3_clear) |->
    $past(enhanced_capture_compare_one_event) || $past(capture_compare_unit_two_event))
    else $error("timer clear without a compare unit event");
  chk_one_timer: assert property (!(timer1_clear && timer3_clear))
    else $error("both timers cleared at once");
  chk_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  chk_start_busy: assert property (conv_start |-> conversion_busy)
    else $error("conversion start while not busy");
  chk_done_idle: assert property (conversion_busy && conv_done
    |=> !conversion_busy)
    else $error("busy stayed after conversion done");
  chk_sleep_delay: assert property (
    $rose(conversion_busy) && !acquiring |-> s_delayed_start)
    else $error("delayed start not seen in time");
  chk_acq_holds: assert property (
    $rose(conversion_busy) && acquiring
    |=> (acquiring || !conversion_busy) [*8])
    else $error("acquisition ended too early");
  chk_ref_onehot: assert property ($onehot(pos_ref_onehot))
    else $error("positive reference select not one-hot");
  chk_route_onehot: assert property ($onehot(neg_input_route))
    else $error("negative input route not one-hot");
endmodule : adcc_top_chk
`default_nettype wire
